// file: hdl/rtrs_rssi_cap.sv
`timescale 1ns/1ps
module rtrs_rssi_cap
  import rtrs_pkg::*;
(
  input  wire logic       mclk_i,
  input  wire logic       sys_rst_i,
  input  wire logic       rx_mode_i,
  input  wire logic       sample_i,
  input  wire logic [4:0] level_i,
  output rtrs_rssi_t      rssi_o
);
  typedef struct packed {
    logic       rx_prev;
    logic       armed;
    rtrs_rssi_t rssi;
  } rtrs_cap_st_t;

  rtrs_cap_st_t st_ff, nxt_st;

  always_comb begin
    nxt_st         = st_ff;
    nxt_st.rx_prev = rx_mode_i;
    if (rx_mode_i && !st_ff.rx_prev) begin
      // a fresh receive entry invalidates the old reading until a new one lands
      nxt_st.armed      = 1'b1;
      nxt_st.rssi.valid = 1'b0;
    end else if (!rx_mode_i) begin
      nxt_st.armed = 1'b0;
    end else if (st_ff.armed && sample_i) begin
      nxt_st.armed      = 1'b0;
      nxt_st.rssi.level = level_i;
      nxt_st.rssi.valid = 1'b1;
    end
  end

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign rssi_o = st_ff.rssi;

  one_sample_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    st_ff.armed && sample_i && rx_mode_i |=> !st_ff.armed && st_ff.rssi.valid
      && st_ff.rssi.level == $past(level_i) ##1 !st_ff.armed)
    else $error("strength sample not taken exactly once");
  entry_inval_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    rx_mode_i && !st_ff.rx_prev |=> !st_ff.rssi.valid && st_ff.armed)
    else $error("strength valid not cleared on receive entry");
endmodule

// file: hdl/rtrs_spi_slave.sv
`timescale 1ns/1ps
// byte 0: bit 7 write flag, bits 5:0 address; byte 1: data, mode 0, msb first
module rtrs_spi_slave
  import rtrs_pkg::*;
(
  input  wire logic       mclk_i,
  input  wire logic       sys_rst_i,
  input  wire logic       spi_sck_i,
  input  wire logic       spi_ss_n_i,
  input  wire logic       spi_mosi_i,
  input  wire logic [7:0] rd_data_i,
  output rtrs_req_t       req_o,
  output logic            spi_miso_o,
  output logic            spi_miso_oe_o
);
  typedef struct packed {
    logic       sck_m, sck_s, sck_p;
    logic       ss_m, ss_s;
    logic       mosi_m, mosi_s;
    logic [4:0] cnt;
    logic [7:0] shin, shout;
    logic       load;
    rtrs_req_t  req;
  } rtrs_spi_st_t;

  rtrs_spi_st_t st_ff, nxt_st;
  logic [7:0]   rx_byte;
  logic         dir_ff, nxt_dir;

  always_comb begin
    nxt_st            = st_ff;
    nxt_st.sck_m      = spi_sck_i;
    nxt_st.sck_s      = st_ff.sck_m;
    nxt_st.sck_p      = st_ff.sck_s;
    nxt_st.ss_m       = spi_ss_n_i;
    nxt_st.ss_s       = st_ff.ss_m;
    nxt_st.mosi_m     = spi_mosi_i;
    nxt_st.mosi_s     = st_ff.mosi_m;
    nxt_st.req.wr_stb = 1'b0;
    nxt_st.load       = 1'b0;
    rx_byte           = {st_ff.shin[6:0], st_ff.mosi_s};
    if (st_ff.load) begin
      nxt_st.shout = rd_data_i;
    end
    if (st_ff.ss_s) begin
      nxt_st.cnt = 5'h00;
    end else if (st_ff.sck_s && !st_ff.sck_p && st_ff.cnt != SPI_DATA_END) begin
      nxt_st.shin = rx_byte;
      nxt_st.cnt  = st_ff.cnt + 5'h01;
      if (nxt_st.cnt == SPI_ADDR_END) begin
        nxt_st.req.addr = rx_byte[5:0];
        nxt_st.shin     = {rx_byte[SPI_DIR_BIT], 7'h00};
        nxt_st.load     = 1'b1;
      end else if (nxt_st.cnt == SPI_DATA_END) begin
        nxt_st.req.wdata  = rx_byte;
        nxt_st.req.wr_stb = dir_ff;
      end
    end else if (!st_ff.sck_s && st_ff.sck_p && st_ff.cnt > SPI_ADDR_END) begin
      nxt_st.shout = {st_ff.shout[6:0], 1'b0};
    end
  end

  // write flag kept apart so the data byte can reuse the input shifter
  assign nxt_dir = (!st_ff.ss_s && st_ff.sck_s && !st_ff.sck_p
                    && st_ff.cnt == SPI_ADDR_END - 5'h01) ? rx_byte[SPI_DIR_BIT] : dir_ff;

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st_ff  <= '{sck_m: 1'b0, sck_s: 1'b0, sck_p: 1'b0, ss_m: 1'b1, ss_s: 1'b1,
                 default: '0};
      dir_ff <= 1'b0;
    end else begin
      st_ff  <= nxt_st;
      dir_ff <= nxt_dir;
    end
  end

  assign req_o         = st_ff.req;
  assign spi_miso_o    = st_ff.shout[7];
  assign spi_miso_oe_o = !st_ff.ss_s;
endmodule

// file: hdl/rtrs_top.sv
`timescale 1ns/1ps
module rtrs_top
  import rtrs_pkg::*;
(
  input  wire logic       mclk_i,
  input  wire logic       sys_rst_i,
  input  wire logic       spi_sck_i,
  input  wire logic       spi_ss_n_i,
  input  wire logic       spi_mosi_i,
  output logic            spi_miso_o,
  output logic            spi_miso_oe_o,
  input  wire logic       rssi_sample_i,
  input  wire logic [4:0] rssi_level_i,
  output logic            rx_mode_o,
  output logic [2:0]      transmit_gain_code_o,
  output logic [5:0]      crystal_trim_o,
  output logic            buffered_clock_output_pin_oe_o,
  output logic [1:0]      oscillator_slope_select_o,
  output logic [2:0]      slope_adj_down_o,
  output logic [2:0]      slope_adj_up_o,
  output logic            power_save_o,
  output logic            carrier_override_o,
  output logic [7:0]      clock_override_o,
  output logic [7:0]      clock_enable_o
);
  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    logic       rx_mode;
    logic       wr_gate;
    logic [2:0] gain;
    logic       clk_dis;
    logic [5:0] trim;
    logic [1:0] slope;
    logic       pwr_save;
    logic       car_ovr;
    logic [7:0] clk_ovr;
    logic [7:0] clk_en;
    logic [2:0] adj_dn;
    logic [2:0] adj_up;
  } rtrs_regs_t;

  rtrs_regs_t regs_ff, nxt_regs;
  rtrs_req_t  req;
  rtrs_rssi_t rssi;
  logic [7:0] rd_data;

  // ------------------------------------------------------------
  // serial access and strength capture
  // ------------------------------------------------------------
  rtrs_spi_slave u_spi (
    .mclk_i        (mclk_i),
    .sys_rst_i     (sys_rst_i),
    .spi_sck_i     (spi_sck_i),
    .spi_ss_n_i    (spi_ss_n_i),
    .spi_mosi_i    (spi_mosi_i),
    .rd_data_i     (rd_data),
    .req_o         (req),
    .spi_miso_o    (spi_miso_o),
    .spi_miso_oe_o (spi_miso_oe_o)
  );

  rtrs_rssi_cap u_rssi (
    .mclk_i    (mclk_i),
    .sys_rst_i (sys_rst_i),
    .rx_mode_i (regs_ff.rx_mode),
    .sample_i  (rssi_sample_i),
    .level_i   (rssi_level_i),
    .rssi_o    (rssi)
  );

  // ------------------------------------------------------------
  // register writes
  // ------------------------------------------------------------
  always_comb begin
    nxt_regs = regs_ff;
    if (req.wr_stb) begin
      case (req.addr)
        ADDR_CTRL: begin
          nxt_regs.rx_mode = req.wdata[BIT_RX_MODE];
        end
        ADDR_ANA: begin
          nxt_regs.wr_gate = req.wdata[BIT_WR_GATE];
        end
        ADDR_PA: begin
          nxt_regs.gain = req.wdata[2:0];
        end
        ADDR_CRY: begin
          nxt_regs.clk_dis = req.wdata[BIT_CLK_DIS];
          nxt_regs.trim    = req.wdata[5:0];
        end
        ADDR_CAL: begin
          nxt_regs.slope = req.wdata[7:6];
        end
        ADDR_PWR: begin
          // closed gate drops the write silently; the bus has no error path
          if (regs_ff.wr_gate) begin
            nxt_regs.pwr_save = req.wdata[BIT_PWR_SAVE];
          end
        end
        ADDR_CAR: begin
          if (regs_ff.wr_gate) begin
            nxt_regs.car_ovr = req.wdata[BIT_CAR_OVR];
          end
        end
        ADDR_CKOV: begin
          nxt_regs.clk_ovr = req.wdata;
        end
        ADDR_CKEN: begin
          nxt_regs.clk_en = req.wdata;
        end
        default: begin
          nxt_regs = regs_ff;
        end
      endcase
    end
    // code 01 is reserved and treated as no adjust
    case (nxt_regs.slope)
      SLOPE_WIDE: begin
        nxt_regs.adj_dn = ADJ_WIDE_DN;
        nxt_regs.adj_up = ADJ_WIDE_UP;
      end
      SLOPE_NARROW: begin
        nxt_regs.adj_dn = ADJ_NARR_DN;
        nxt_regs.adj_up = ADJ_NARR_UP;
      end
      default: begin
        nxt_regs.adj_dn = 3'h0;
        nxt_regs.adj_up = 3'h0;
      end
    endcase
  end

  // all fields reset to zero, which leaves the clock output driven
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      regs_ff <= '0;
    end else begin
      regs_ff <= nxt_regs;
    end
  end

  // ------------------------------------------------------------
  // read mux
  // ------------------------------------------------------------
  always_comb begin
    rd_data = REG_RST_VAL;
    case (req.addr)
      ADDR_CTRL: rd_data[BIT_RX_MODE] = regs_ff.rx_mode;
      ADDR_ANA:  rd_data[BIT_WR_GATE] = regs_ff.wr_gate;
      ADDR_RSSI: rd_data[5:0]         = {rssi.valid, rssi.level};
      ADDR_PA:   rd_data[2:0]         = regs_ff.gain;
      ADDR_CRY:  rd_data[6:0]         = {regs_ff.clk_dis, regs_ff.trim};
      // slope field reads back as zero: it is write-only
      ADDR_CAL:  rd_data              = REG_RST_VAL;
      ADDR_PWR:  rd_data[BIT_PWR_SAVE] = regs_ff.pwr_save;
      ADDR_CAR:  rd_data[BIT_CAR_OVR]  = regs_ff.car_ovr;
      ADDR_CKOV: rd_data              = regs_ff.clk_ovr;
      ADDR_CKEN: rd_data              = regs_ff.clk_en;
      default:   rd_data              = REG_RST_VAL;
    endcase
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign rx_mode_o                      = regs_ff.rx_mode;
  assign transmit_gain_code_o           = regs_ff.gain;
  assign crystal_trim_o                 = regs_ff.trim;
  assign buffered_clock_output_pin_oe_o = !regs_ff.clk_dis;
  assign oscillator_slope_select_o      = regs_ff.slope;
  assign slope_adj_down_o               = regs_ff.adj_dn;
  assign slope_adj_up_o                 = regs_ff.adj_up;
  assign power_save_o                   = regs_ff.pwr_save;
  assign carrier_override_o             = regs_ff.car_ovr;
  assign clock_override_o               = regs_ff.clk_ovr;
  assign clock_enable_o                 = regs_ff.clk_en;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);

  function automatic logic wr_to(input rtrs_req_t r, input logic [5:0] a);
    wr_to = r.wr_stb && r.addr == a;
  endfunction

  pwr_gated_a: assert property (
    wr_to(req, ADDR_PWR) && !regs_ff.wr_gate |=> $stable(power_save_o) [*2])
    else $error("power control changed while write gate closed");
  pwr_open_a: assert property (
    wr_to(req, ADDR_PWR) && regs_ff.wr_gate |=> power_save_o == $past(req.wdata[7]))
    else $error("power control write not taken with gate open");
  car_gate_a: assert property (
    wr_to(req, ADDR_CAR) |=> carrier_override_o
      == ($past(regs_ff.wr_gate) ? $past(req.wdata[7]) : $past(carrier_override_o)))
    else $error("carrier override gating wrong");
  gain_wr_a: assert property (
    wr_to(req, ADDR_PA) |=> transmit_gain_code_o == $past(req.wdata[2:0]))
    else $error("gain code not updated");
  clk_out_a: assert property (
    wr_to(req, ADDR_CRY) |=> buffered_clock_output_pin_oe_o == !$past(req.wdata[6])
      && crystal_trim_o == $past(req.wdata[5:0]))
    else $error("crystal register write not applied");
  clk_rst_a: assert property (
    $past(sys_rst_i) |-> buffered_clock_output_pin_oe_o && crystal_trim_o == 6'h00)
    else $error("clock output not enabled after reset");
  slope_dec_a: assert property (
    wr_to(req, ADDR_CAL) |=> (slope_adj_down_o == 3'h5 && slope_adj_up_o == 3'h5)
      == ($past(req.wdata[7:6]) == 2'h3)
      && (slope_adj_down_o == 3'h2 && slope_adj_up_o == 3'h3)
      == ($past(req.wdata[7:6]) == 2'h2))
    else $error("slope decode wrong");
  slope_rd_a: assert property (
    req.addr == ADDR_CAL |-> rd_data == 8'h00)
    else $error("slope field visible on read");
  rssi_rd_a: assert property (
    req.addr == ADDR_RSSI |-> rd_data[7:6] == 2'h0 && rd_data[5] == rssi.valid)
    else $error("strength readout malformed");
  resv_rd_a: assert property (
    req.addr == ADDR_PA |-> rd_data[7:3] == 5'h00)
    else $error("reserved gain bits not zero");
  ctrl_rd_a: assert property (
    req.addr == ADDR_CTRL |-> rd_data == {rx_mode_o, 7'h00})
    else $error("receive mode bit misread");
  gate_rd_a: assert property (
    req.addr == ADDR_ANA |-> rd_data == {1'b0, regs_ff.wr_gate, 6'h00})
    else $error("write gate misread");
  gain_rd_a: assert property (
    req.addr == ADDR_PA |-> rd_data[2:0] == transmit_gain_code_o)
    else $error("gain code misread");
  cry_rd_a: assert property (
    req.addr == ADDR_CRY |-> rd_data
      == {1'b0, !buffered_clock_output_pin_oe_o, crystal_trim_o})
    else $error("crystal register misread");
  pwr_rd_a: assert property (
    req.addr == ADDR_PWR |-> rd_data == {power_save_o, 7'h00})
    else $error("power control misread");
  car_rd_a: assert property (
    req.addr == ADDR_CAR |-> rd_data == {carrier_override_o, 7'h00})
    else $error("carrier override misread");
  ovr_rd_a: assert property (
    req.addr == ADDR_CKOV |-> rd_data == clock_override_o)
    else $error("clock override misread");
  en_rd_a: assert property (
    req.addr == ADDR_CKEN |-> rd_data == clock_enable_o)
    else $error("clock enable misread");
  rssi_lvl_a: assert property (
    req.addr == ADDR_RSSI |-> rd_data[4:0] == rssi.level)
    else $error("strength level misread");
  unmap_rd_a: assert property (
    req.addr > ADDR_CKEN |-> rd_data == 8'h00)
    else $error("unmapped address reads nonzero");

  // ------------------------------------------------------------
  // write path checks
  // ------------------------------------------------------------
  rx_wr_a: assert property (
    wr_to(req, ADDR_CTRL) |=> rx_mode_o == $past(req.wdata[7]))
    else $error("receive mode write not applied");
  gate_wr_a: assert property (
    wr_to(req, ADDR_ANA) |=> regs_ff.wr_gate == $past(req.wdata[6]))
    else $error("write gate not updated");
  ckov_wr_a: assert property (
    wr_to(req, ADDR_CKOV) |=> clock_override_o == $past(req.wdata))
    else $error("clock override not stored");
  cken_wr_a: assert property (
    wr_to(req, ADDR_CKEN) |=> clock_enable_o == $past(req.wdata))
    else $error("clock enable not stored");
  slope_rsv_a: assert property (
    oscillator_slope_select_o == 2'h1
      |-> slope_adj_down_o == 3'h0 && slope_adj_up_o == 3'h0)
    else $error("reserved slope code adjusts");
  adj_wide_a: assert property (
    oscillator_slope_select_o == 2'h3 |-> slope_adj_down_o == 3'h5 && slope_adj_up_o == 3'h5)
    else $error("wide slope adjust wrong");
  adj_narr_a: assert property (
    oscillator_slope_select_o == 2'h2 |-> slope_adj_down_o == 3'h2 && slope_adj_up_o == 3'h3)
    else $error("narrow slope adjust wrong");
  idle_hold_a: assert property (
    !req.wr_stb |=> regs_ff == $past(regs_ff))
    else $error("register changed without a write");
  ro_wr_a: assert property (
    wr_to(req, ADDR_RSSI) |=> regs_ff == $past(regs_ff))
    else $error("strength register write changed state");
  unmap_wr_a: assert property (
    req.wr_stb && req.addr > ADDR_CKEN |=> regs_ff == $past(regs_ff))
    else $error("unmapped write changed a register");

  // ------------------------------------------------------------
  // coverage
  // ------------------------------------------------------------
  gated_drop_c: cover property (wr_to(req, ADDR_PWR) && !regs_ff.wr_gate);
  gated_take_c: cover property (wr_to(req, ADDR_ANA) ##[1:1000] wr_to(req, ADDR_PWR)
    ##1 power_save_o);
  rssi_cap_c:   cover property (rx_mode_o ##[1:50] rssi.valid);
  slope_set_c:  cover property (slope_adj_down_o == 3'h5);
  slope_nar_c:  cover property (slope_adj_up_o == 3'h3);
endmodule

// file: include/rtrs_pkg.sv
package rtrs_pkg;
  // ------------------------------------------------------------
  // register offsets
  // ------------------------------------------------------------
  localparam logic [5:0] ADDR_CTRL = 6'h03;
  localparam logic [5:0] ADDR_ANA  = 6'h20;
  localparam logic [5:0] ADDR_RSSI = 6'h22;
  localparam logic [5:0] ADDR_PA   = 6'h23;
  localparam logic [5:0] ADDR_CRY  = 6'h24;
  localparam logic [5:0] ADDR_CAL  = 6'h26;
  localparam logic [5:0] ADDR_PWR  = 6'h2E;
  localparam logic [5:0] ADDR_CAR  = 6'h2F;
  localparam logic [5:0] ADDR_CKOV = 6'h32;
  localparam logic [5:0] ADDR_CKEN = 6'h33;
  // ------------------------------------------------------------
  // field positions and reset values
  // ------------------------------------------------------------
  localparam int         BIT_RX_MODE  = 7;
  localparam int         BIT_WR_GATE  = 6;
  localparam int         BIT_CLK_DIS  = 6;
  localparam int         BIT_PWR_SAVE = 7;
  localparam int         BIT_CAR_OVR  = 7;
  localparam int         BIT_VALID    = 5;
  localparam int         SPI_DIR_BIT  = 7;
  localparam logic [7:0] REG_RST_VAL  = 8'h00;
  localparam logic [4:0] SPI_ADDR_END = 5'h08;
  localparam logic [4:0] SPI_DATA_END = 5'h10;
  // ------------------------------------------------------------
  // oscillator slope decode
  // ------------------------------------------------------------
  localparam logic [1:0] SLOPE_WIDE   = 2'h3;
  localparam logic [1:0] SLOPE_NARROW = 2'h2;
  localparam logic [2:0] ADJ_WIDE_DN  = 3'h5;
  localparam logic [2:0] ADJ_WIDE_UP  = 3'h5;
  localparam logic [2:0] ADJ_NARR_DN  = 3'h2;
  localparam logic [2:0] ADJ_NARR_UP  = 3'h3;

  typedef struct packed {
    logic       wr_stb;
    logic [5:0] addr;
    logic [7:0] wdata;
  } rtrs_req_t;

  typedef struct packed {
    logic       valid;
    logic [4:0] level;
  } rtrs_rssi_t;
endpackage

// file: verif/rtrs_host_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// host controller: spi mode 0 master, one register per select
// ------------------------------------------------------------
module rtrs_host_model
  import rtrs_pkg::*;
(
  input  wire logic mclk_i,
  input  wire logic miso_i,
  output logic      sck_o,
  output logic      ss_n_o,
  output logic      mosi_o
);
  // six cycles a half period: miso moves up to four cycles after our falling edge
  localparam int HALF = 6;

  initial begin
    sck_o  = 1'b0;
    ss_n_o = 1'b1;
    mosi_o = 1'b0;
  end

  task automatic wait_n(input int n);
    repeat (n) @(negedge mclk_i);
  endtask

  task automatic xfer(input logic wr, input logic [5:0] addr, input logic [7:0] wdata,
                      output logic [7:0] rdata);
    logic [15:0] frame;
    frame = {wr, 1'b0, addr, wdata};
    rdata = 8'h00;
    @(negedge mclk_i);
    ss_n_o = 1'b0;
    wait_n(4);
    for (int i = 15; i >= 0; i--) begin
      mosi_o = frame[i];
      wait_n(HALF);
      if (i < 8) begin
        rdata = {rdata[6:0], miso_i};
      end
      sck_o = 1'b1;
      wait_n(HALF);
      sck_o = 1'b0;
    end
    wait_n(HALF);
    ss_n_o = 1'b1;
    // released data line must not keep showing the last bit
    mosi_o = ~mosi_o;
    wait_n(6);
  endtask

  // start-up sequence; reserved bits always written as zero
  task automatic init_device();
    logic [7:0] rd;
    xfer(1'b1, ADDR_CKOV, 8'h41, rd);
    xfer(1'b1, ADDR_CKEN, 8'h41, rd);
    xfer(1'b1, ADDR_CAL, 8'hC0, rd);
    xfer(1'b1, ADDR_PA, 8'h07, rd);
    xfer(1'b1, ADDR_ANA, 8'h40, rd);
    xfer(1'b1, ADDR_PWR, 8'h80, rd);
  endtask
endmodule

// file: verif/testbench.sv
`timescale 1ns/1ps
module testbench
  import rtrs_pkg::*;
;
  logic       mclk, sys_rst, sck, ss_n, mosi, miso, miso_oe, sample, rx_mode;
  logic       clk_oe, pwr, car;
  logic [4:0] level;
  logic [2:0] gain, adj_dn, adj_up;
  logic [5:0] trim;
  logic [1:0] slope;
  logic [7:0] ckov, cken;
  wire logic  miso_line;
  int         err_count = 0;
  int         checked = 0;

  assign miso_line = miso_oe ? miso : 1'bz;

  rtrs_top u_rtrs_top (
    .mclk_i(mclk), .sys_rst_i(sys_rst), .spi_sck_i(sck), .spi_ss_n_i(ss_n),
    .spi_mosi_i(mosi), .spi_miso_o(miso), .spi_miso_oe_o(miso_oe),
    .rssi_sample_i(sample), .rssi_level_i(level), .rx_mode_o(rx_mode),
    .transmit_gain_code_o(gain), .crystal_trim_o(trim),
    .buffered_clock_output_pin_oe_o(clk_oe), .oscillator_slope_select_o(slope),
    .slope_adj_down_o(adj_dn), .slope_adj_up_o(adj_up), .power_save_o(pwr),
    .carrier_override_o(car), .clock_override_o(ckov), .clock_enable_o(cken)
  );

  rtrs_host_model u_rtrs_host_model (
    .mclk_i(mclk), .miso_i(miso_line), .sck_o(sck), .ss_n_o(ss_n), .mosi_o(mosi)
  );

  always #10 mclk = ~mclk;

  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic chk(input string name, input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    logic [7:0] rd;
    u_rtrs_host_model.xfer(1'b1, a, d, rd);
  endtask

  task automatic rd_chk(input string name, input logic [5:0] a, input logic [7:0] exp);
    logic [7:0] rd;
    u_rtrs_host_model.xfer(1'b0, a, 8'h00, rd);
    chk(name, rd, exp);
  endtask

  task automatic pulse(input logic [4:0] l);
    @(negedge mclk);
    sample = 1'b1;
    level  = l;
    @(negedge mclk);
    sample = 1'b0;
    level  = ~l;
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    logic [5:0] regs [6];
    regs = '{ADDR_PA, ADDR_CRY, ADDR_PWR, ADDR_CAR, ADDR_CKOV, ADDR_CKEN};
    chk("clk_oe", {7'h0, clk_oe}, 8'h01);
    chk("miso_oe", {7'h0, miso_oe}, 8'h00);
    chk("outs", {gain, pwr, car, slope, rx_mode}, 8'h00);
    foreach (regs[i]) begin
      rd_chk("reset_rd", regs[i], REG_RST_VAL);
    end
    rd_chk("rssi_rst", ADDR_RSSI, 8'h00);
    $display("test reset done");
  endtask

  task automatic t_gain();
    for (int c = 0; c < 8; c++) begin
      wr(ADDR_PA, 8'(c));
      chk("gain", {5'h0, gain}, 8'(c));
      rd_chk("gain_rd", ADDR_PA, 8'(c));
    end
    $display("test gain done");
  endtask

  task automatic t_crystal();
    wr(ADDR_CRY, 8'h7F);
    chk("trim", {2'h0, trim}, 8'h3F);
    chk("clk_oe", {7'h0, clk_oe}, 8'h00);
    rd_chk("cry_rd", ADDR_CRY, 8'h7F);
    wr(ADDR_CRY, 8'h15);
    chk("clk_oe", {7'h0, clk_oe}, 8'h01);
    chk("trim", {2'h0, trim}, 8'h15);
    $display("test crystal done");
  endtask

  task automatic t_slope();
    logic [2:0] dn [4];
    logic [2:0] up [4];
    dn = '{3'h0, 3'h0, 3'h2, 3'h5};
    up = '{3'h0, 3'h0, 3'h3, 3'h5};
    for (int s = 0; s < 4; s++) begin
      wr(ADDR_CAL, {2'(s), 6'h00});
      chk("slope", {6'h0, slope}, 8'(s));
      chk("adj", {2'h0, adj_dn, adj_up}, {2'h0, dn[s], up[s]});
      rd_chk("cal_rd", ADDR_CAL, 8'h00);
    end
    $display("test slope done");
  endtask

  task automatic t_gate();
    wr(ADDR_PWR, 8'h80);
    wr(ADDR_CAR, 8'h80);
    chk("pwr", {7'h0, pwr}, 8'h00);
    chk("car", {7'h0, car}, 8'h00);
    wr(ADDR_ANA, 8'h40);
    rd_chk("ana_rd", ADDR_ANA, 8'h40);
    wr(ADDR_PWR, 8'h80);
    wr(ADDR_CAR, 8'h80);
    chk("pwr", {7'h0, pwr}, 8'h01);
    chk("car", {7'h0, car}, 8'h01);
    wr(ADDR_ANA, 8'h00);
    wr(ADDR_PWR, 8'h00);
    chk("pwr", {7'h0, pwr}, 8'h01);
    rd_chk("pwr_rd", ADDR_PWR, 8'h80);
    $display("test gate done");
  endtask

  task automatic t_rssi();
    logic [7:0] rd;
    pulse(5'h09);
    rd_chk("rssi_idle", ADDR_RSSI, 8'h00);
    wr(ADDR_CTRL, 8'h80);
    chk("rx", {7'h0, rx_mode}, 8'h01);
    pulse(5'h15);
    pulse(5'h0A);
    rd_chk("rssi", ADDR_RSSI, 8'h35);
    wr(ADDR_RSSI, 8'hFF);
    rd_chk("rssi_ro", ADDR_RSSI, 8'h35);
    wr(ADDR_CTRL, 8'h00);
    wr(ADDR_CTRL, 8'h80);
    u_rtrs_host_model.xfer(1'b0, ADDR_RSSI, 8'h00, rd);
    chk("rssi_valid", rd & 8'hE0, 8'h00);
    pulse(5'h1F);
    rd_chk("rssi_new", ADDR_RSSI, 8'h3F);
    $display("test rssi done");
  endtask

  task automatic t_init();
    u_rtrs_host_model.init_device();
    chk("ckov", ckov, 8'h41);
    chk("cken", cken, 8'h41);
    chk("init", {gain, pwr, 2'h0, slope}, 8'hF3);
    wr(6'h3A, 8'h00);
    rd_chk("unmapped", 6'h3A, 8'h00);
    $display("test init done");
  endtask

  initial begin
    mclk    = 1'b0;
    sys_rst = 1'b1;
    sample  = 1'b0;
    level   = 5'h00;
    repeat (5) @(negedge mclk);
    sys_rst = 1'b0;
    repeat (4) @(negedge mclk);
    t_reset();
    t_gain();
    t_crystal();
    t_slope();
    t_gate();
    t_rssi();
    t_init();
    results();
  end

  // about 60 accesses of some 210 cycles each; generous margin
  initial begin
    repeat (40000) @(posedge mclk);
    err_count++;
    results();
  end
endmodule
